// ### hdl/sc_pkg.sv
// sc_pkg: constants, register map and state layout of the start-up sequencer
// assumes a 100 MHz sys_clk and a byte-wide serial register map
package sc_pkg;
	// timing
	localparam int CLK_MHZ = 100;
	localparam int POR_MS = 20;
	localparam int STAB_DEF_MS = 50;
	localparam int MF_TRI_NS = 45;
	localparam int CYC_PER_MS = CLK_MHZ * 1000;
	localparam int POR_CYC = POR_MS * CYC_PER_MS;
	localparam int MF_TRI_CYC = (MF_TRI_NS * CLK_MHZ) / 1000;
	typedef logic [7:0] sc_byte_type;
	typedef logic [14:0] sc_addr_type;
	// synchroniser lane positions
	localparam int SYNC_W = 22;
	localparam int SI_MF = 0;
	localparam int SI_FLT = 8;
	localparam int SI_HPS = 12;
	localparam int SI_RST = 13;
	localparam int SI_SUP = 14;
	localparam int SI_SCK = 15;
	localparam int SI_CSB = 16;
	localparam int SI_SDI = 17;
	localparam int SI_SLK = 18;
	localparam int SI_ALK = 19;
	localparam int SI_PLK = 20;
	localparam int SI_FLK = 21;
	// register offsets
	localparam sc_addr_type A_IO_UPD = 15'h0005;
	localparam sc_addr_type A_REV = 15'h000A;
	localparam sc_addr_type A_STAB = 15'h0106;
	localparam sc_addr_type A_MF_DIR = 15'h0200;
	localparam sc_addr_type A_MF_VAL = 15'h0201;
	localparam sc_addr_type A_SYNC_PIN = 15'h0202;
	localparam sc_addr_type A_IRQ_MODE = 15'h0208;
	localparam sc_addr_type A_IRQ_MASK = 15'h020A;
	localparam sc_addr_type A_WD_LO = 15'h0210;
	localparam sc_addr_type A_WD_HI = 15'h0211;
	localparam sc_addr_type A_OMC_A = 15'h0400;
	localparam sc_addr_type A_OMC_B = 15'h0403;
	localparam sc_addr_type A_VCO = 15'h0405;
	localparam sc_addr_type A_SYNC_MODE = 15'h0500;
	localparam sc_addr_type A_OUT_EN = 15'h0501;
	localparam sc_addr_type A_LOOP = 15'h0A01;
	localparam sc_addr_type A_SSYNC = 15'h0A02;
	localparam sc_addr_type A_CLR = 15'h0A03;
	localparam sc_addr_type A_IRQ_CLR = 15'h0A04;
	localparam sc_addr_type A_PLL_ST = 15'h0D01;
	localparam sc_addr_type A_IRQ_MON = 15'h0D02;
	// bit positions
	localparam int B_IOUPD = 0;
	localparam int B_VCOCAL = 0;
	localparam int B_FREERUN = 5;
	localparam int B_SSYNC = 1;
	localparam int B_CLR_WD = 0;
	localparam int B_CLR_ALL = 1;
	localparam int B_SYNC_PEN = 3;
	localparam int ST_SLK = 0;
	localparam int ST_STABLE = 1;
	localparam int ST_OUTPUT_MULTIPLIER_LOOP = 2;
	localparam int ST_PLK = 3;
	localparam int ST_FLK = 4;
	// interrupt events
	localparam int EV_STABLE = 0;
	localparam int EV_ALOCK = 1;
	localparam int EV_AUNLOCK = 2;
	localparam int EV_PLOCK = 3;
	localparam int EV_FLOCK = 4;
	localparam int EV_SYNC = 5;
	localparam int EV_WD = 6;
	localparam int EV_FREE = 7;
	// modes and strap codes
	localparam logic [1:0] SYNC_ON_PLOCK = 2'h1;
	localparam logic [1:0] SYNC_ON_FLOCK = 2'h2;
	localparam logic [1:0] IRQ_OD_N = 2'h0;
	localparam logic [1:0] IRQ_OD_P = 2'h1;
	localparam logic [1:0] IRQ_PP_HI = 2'h2;
	localparam logic [1:0] IRQ_PP_LO = 2'h3;
	localparam logic [1:0] LVL_LO = 2'h0;
	localparam logic [1:0] LVL_FLT = 2'h1;
	localparam logic [1:0] LVL_HI = 2'h2;
	localparam logic [3:0] CODE_SPI = 4'h0;
	localparam logic [3:0] CODE_NO_EEP = 4'h4;
	localparam logic [3:0] LVL_RADIX = 4'h3;
	// configuration bytes, pending and active copies
	typedef struct packed {
		sc_byte_type stab, mf_dir, mf_val, sync_pin, irq_mode, irq_mask, wd_lo, wd_hi;
		sc_byte_type omc_a, omc_b, vco, sync_mode, out_en, loop, ssync;
	} sc_regs_type;
	localparam sc_regs_type REGS_RST = '{stab: 8'h32, omc_a: 8'h81, omc_b: 8'h07,
		vco: 8'h20, default: 8'h00};
	typedef enum logic [3:0] {
		SP_IDLE = 4'b0001,
		SP_INSTR = 4'b0010,
		SP_DATA = 4'b0100,
		SP_DONE = 4'b1000
	} sc_spi_type;
	typedef struct packed {
		logic [SYNC_W-1:0] s1, s2;
		logic [31:0] por_cnt;
		logic por_act, dev_rst;
		logic hard_pin, spi_mode, eep_load;
		logic [2:0] i2c_addr, eep_prof;
		sc_regs_type pend, act;
		sc_spi_type spi_st;
		logic sck_q, rw, sdo, sdo_oe;
		logic [4:0] bit_cnt;
		logic [15:0] shreg;
		sc_addr_type addr;
		sc_byte_type dat;
		logic [31:0] stab_pre, wd_pre;
		sc_byte_type stab_ms;
		logic [15:0] wd_ms;
		logic stable, alk_q, plk_q, flk_q, pin_q, vco_q, ssync_q, free_q;
		logic cal_start, acquire, dist_sync;
		sc_byte_type irq_mon;
		logic irq_out, irq_oe;
	} sc_state_type;
	localparam sc_state_type ST_RST = '{por_act: 1'b1, dev_rst: 1'b1, pend: REGS_RST,
		act: REGS_RST, spi_st: SP_IDLE, default: '0};
endpackage : sc_pkg

// ### hdl/sc_startup_config_sequencer.sv
// sc_startup_config_sequencer: power-up reset, strap capture, serial register
// map with I/O update, output PLL calibration kick, sync, IRQ and watchdog.
// assumes pins and status inputs are asynchronous; analog blocks sit outside.
`timescale 1ns/1ps
module sc_startup_config_sequencer #(
	parameter int POR_CYCLES = sc_pkg::POR_CYC,
	parameter int MS_CYCLES = sc_pkg::CYC_PER_MS,
	parameter logic [7:0] SILICON_REV = 8'h5A // arbitrary identity value
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic supplies_ok,
	input wire logic reset_pin_n,
	input wire logic hard_pin_select,
	input wire logic [3:0] strap_float,
	input wire sc_pkg::sc_byte_type mf_in,
	output logic [7:0] mf_out,
	output logic [7:0] mf_oe,
	input wire logic spi_sclk,
	input wire logic spi_csb,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	input wire logic system_clock_multiplier_pll_locked,
	input wire logic output_multiplier_loop_locked,
	input wire logic digital_loop_phase_lock,
	input wire logic digital_loop_freq_lock,
	output logic device_reset,
	output logic hard_pin_mode,
	output logic serial_is_spi,
	output logic [2:0] i2c_addr_sel,
	output logic eeprom_load,
	output logic [2:0] eeprom_profile,
	output logic system_clock_multiplier_stable,
	output logic user_free_run,
	output logic digital_loop_acquire,
	output logic output_multiplier_loop_cal_start,
	output sc_pkg::sc_byte_type output_multiplier_loop_cfg_a,
	output sc_pkg::sc_byte_type output_multiplier_loop_cfg_b,
	output sc_pkg::sc_byte_type dist_out_enable,
	output logic dist_sync,
	output logic irq_out,
	output logic irq_oe
);
	import sc_pkg::*;

	sc_state_type s;
	sc_state_type nxt_s;

	// three-level strap pair to a code 0..8
	// a floating pad counts as the middle level
	function automatic logic [3:0] tri_code(logic hi, logic hi_f, logic lo, logic lo_f);
		logic [1:0] lh;
		logic [1:0] ll;
		lh = hi_f ? LVL_FLT : (hi ? LVL_HI : LVL_LO);
		ll = lo_f ? LVL_FLT : (lo ? LVL_HI : LVL_LO);
		return 4'({2'h0, lh} * LVL_RADIX + {2'h0, ll});
	endfunction : tri_code

	logic [SYNC_W-1:0] sy;
	logic rst_now;
	logic sck_rise;
	logic sck_fall;
	logic wr;
	sc_addr_type wr_addr;
	sc_addr_type rd_addr;
	sc_byte_type wr_data;
	sc_byte_type rdata;
	sc_byte_type ev;
	sc_byte_type clr;
	logic [3:0] code_p;
	logic [3:0] code_q;
	logic wd_hit;
	logic [2:0] pin_idx;
	logic irq_act;

	// next-state logic for the whole block
	always_comb begin
		nxt_s = s;
		wr = 1'b0;
		wr_addr = s.addr;
		wr_data = '0;
		ev = '0;
		clr = '0;
		wd_hit = 1'b0;
		// sync pin index, read by the edge detect and by its delay flop
		pin_idx = s.act.sync_pin[2:0];
		// two-flop synchronisers on every asynchronous input
		nxt_s.s1 = {digital_loop_freq_lock, digital_loop_phase_lock, output_multiplier_loop_locked, system_clock_multiplier_pll_locked,
			spi_sdi, spi_csb, spi_sclk, supplies_ok, reset_pin_n, hard_pin_select,
			strap_float, mf_in};
		nxt_s.s2 = s.s1;
		sy = s.s2;
		// power-up pulse restarts whenever supplies drop
		if (!sy[SI_SUP]) begin
			nxt_s.por_cnt = 32'(POR_CYCLES);
		end else if (s.por_cnt != '0) begin
			nxt_s.por_cnt = s.por_cnt - 32'h1;
		end
		nxt_s.por_act = (nxt_s.por_cnt != '0);
		rst_now = s.por_act | ~sy[SI_SUP] | ~sy[SI_RST];
		nxt_s.dev_rst = rst_now;
		code_p = tri_code(sy[SI_MF+1], sy[SI_FLT+1], sy[SI_MF], sy[SI_FLT]);
		code_q = tri_code(sy[SI_MF+3], sy[SI_FLT+3], sy[SI_MF+2], sy[SI_FLT+2]);
		sck_rise = sy[SI_SCK] & ~s.sck_q;
		sck_fall = ~sy[SI_SCK] & s.sck_q;
		// address as it will stand once the sixteenth bit is in
		rd_addr = {s.shreg[13:0], sy[SI_SDI]};
		nxt_s.sck_q = sy[SI_SCK];
		// read mux: pending copies read back before update
		unique case (rd_addr)
			A_REV: rdata = SILICON_REV;
			A_STAB: rdata = s.pend.stab;
			A_MF_DIR: rdata = s.pend.mf_dir;
			A_MF_VAL: rdata = s.pend.mf_val;
			A_SYNC_PIN: rdata = s.pend.sync_pin;
			A_IRQ_MODE: rdata = s.pend.irq_mode;
			A_IRQ_MASK: rdata = s.pend.irq_mask;
			A_WD_LO: rdata = s.pend.wd_lo;
			A_WD_HI: rdata = s.pend.wd_hi;
			A_OMC_A: rdata = s.pend.omc_a;
			A_OMC_B: rdata = s.pend.omc_b;
			A_VCO: rdata = s.pend.vco;
			A_SYNC_MODE: rdata = s.pend.sync_mode;
			A_OUT_EN: rdata = s.pend.out_en;
			A_LOOP: rdata = s.pend.loop;
			A_SSYNC: rdata = s.pend.ssync;
			A_PLL_ST: rdata = {3'h0, sy[SI_FLK], sy[SI_PLK], sy[SI_ALK], s.stable,
				sy[SI_SLK]};
			A_IRQ_MON: rdata = s.irq_mon;
			default: rdata = '0;
		endcase
		if (rst_now) begin
			// register copies, port state, timers, status and pulses back to defaults; straps keep their value; pins float as inputs
			nxt_s.pend = REGS_RST;
			nxt_s.act = REGS_RST;
			nxt_s.spi_st = SP_IDLE;
			nxt_s.sdo_oe = 1'b0;
			nxt_s.stable = 1'b0;
			nxt_s.stab_ms = '0;
			nxt_s.stab_pre = '0;
			nxt_s.wd_ms = '0;
			nxt_s.wd_pre = '0;
			nxt_s.irq_mon = '0;
			nxt_s.cal_start = 1'b0;
			nxt_s.acquire = 1'b0;
			nxt_s.dist_sync = 1'b0;
			nxt_s.vco_q = 1'b0;
			nxt_s.ssync_q = 1'b0;
			nxt_s.free_q = 1'b0;
		end else begin
			// straps latched once at release and then left alone
			// hard-pin mode clears the SPI select and EEPROM load; address and profile codes still latch from the straps
			if (s.dev_rst) begin
				nxt_s.hard_pin = sy[SI_HPS];
				nxt_s.spi_mode = ~sy[SI_HPS] & (code_p == CODE_SPI);
				nxt_s.i2c_addr = (code_p == CODE_SPI) ? 3'h0 : 3'(code_p - 4'h1);
				nxt_s.eep_load = ~sy[SI_HPS] & (code_q != CODE_NO_EEP);
				nxt_s.eep_prof = (code_q < CODE_NO_EEP) ? code_q[2:0] :
					3'(code_q - 4'h1);
			end
			// serial port, single-byte transfers, MSB first, sampled on rising clock
			// sclk, csb and sdi share one synchroniser lag, so their order holds;
			// the host must keep each sclk level for at least 8 cycles
			if (sy[SI_CSB] || !s.spi_mode) begin
				nxt_s.spi_st = SP_IDLE;
				nxt_s.sdo_oe = 1'b0;
				nxt_s.bit_cnt = '0;
			end else begin
				unique case (s.spi_st)
					SP_IDLE: begin
						nxt_s.spi_st = SP_INSTR;
						nxt_s.bit_cnt = '0;
					end
					SP_INSTR: if (sck_rise) begin
						nxt_s.shreg = {s.shreg[14:0], sy[SI_SDI]};
						nxt_s.bit_cnt = s.bit_cnt + 5'h1;
						if (s.bit_cnt == 5'hF) begin
							nxt_s.rw = s.shreg[14];
							nxt_s.addr = rd_addr;
							nxt_s.dat = rdata;
							nxt_s.bit_cnt = '0;
							nxt_s.spi_st = SP_DATA;
						end
					end
					SP_DATA: begin
						if (sck_fall && s.rw) begin
							nxt_s.sdo = s.dat[7];
							nxt_s.sdo_oe = 1'b1;
						end
						if (sck_rise) begin
							nxt_s.bit_cnt = s.bit_cnt + 5'h1;
							nxt_s.dat = {s.dat[6:0], sy[SI_SDI]};
							if (s.bit_cnt == 5'h7) begin
								wr = ~s.rw;
								wr_data = {s.dat[6:0], sy[SI_SDI]};
								nxt_s.spi_st = SP_DONE;
							end
						end
					end
					SP_DONE: nxt_s.sdo_oe = s.sdo_oe;
				endcase
			end
			// writes land in the pending copy
			// unmapped offsets fall through untouched
			if (wr) begin
				unique case (wr_addr)
					A_STAB: nxt_s.pend.stab = wr_data;
					A_MF_DIR: nxt_s.pend.mf_dir = wr_data;
					A_MF_VAL: nxt_s.pend.mf_val = wr_data;
					A_SYNC_PIN: nxt_s.pend.sync_pin = wr_data;
					A_IRQ_MODE: nxt_s.pend.irq_mode = wr_data;
					A_IRQ_MASK: nxt_s.pend.irq_mask = wr_data;
					A_WD_LO: nxt_s.pend.wd_lo = wr_data;
					A_WD_HI: nxt_s.pend.wd_hi = wr_data;
					A_OMC_A: nxt_s.pend.omc_a = wr_data;
					A_OMC_B: nxt_s.pend.omc_b = wr_data;
					A_VCO: nxt_s.pend.vco = wr_data;
					A_SYNC_MODE: nxt_s.pend.sync_mode = wr_data;
					A_OUT_EN: nxt_s.pend.out_en = wr_data;
					A_LOOP: nxt_s.pend.loop = wr_data;
					A_SSYNC: nxt_s.pend.ssync = wr_data;
					A_IRQ_CLR: clr = wr_data;
					A_CLR: begin
						if (wr_data[B_CLR_ALL]) clr = 8'hFF;
						wd_hit = wr_data[B_CLR_WD];
					end
					default: ;
				endcase
				if (wr_addr == A_IO_UPD && wr_data[B_IOUPD]) begin
					nxt_s.act = nxt_s.pend;
				end
			end
			// edge detects on committed control bits
			// delay flops reset to the idle levels, so no false edge after reset
			nxt_s.vco_q = s.act.vco[B_VCOCAL];
			nxt_s.cal_start = s.act.vco[B_VCOCAL] & ~s.vco_q;
			nxt_s.free_q = s.act.loop[B_FREERUN];
			nxt_s.acquire = ~s.act.loop[B_FREERUN] & s.free_q;
			ev[EV_FREE] = s.act.loop[B_FREERUN] & ~s.free_q;
			nxt_s.ssync_q = s.act.ssync[B_SSYNC];
			nxt_s.dist_sync = (s.ssync_q & ~s.act.ssync[B_SSYNC]) |
				(s.act.sync_pin[B_SYNC_PEN] & sy[SI_MF+pin_idx] & ~s.pin_q) |
				(s.act.sync_mode[1:0] == SYNC_ON_PLOCK && sy[SI_PLK] && !s.plk_q) |
				(s.act.sync_mode[1:0] == SYNC_ON_FLOCK && sy[SI_FLK] && !s.flk_q);
			ev[EV_SYNC] = s.dist_sync;
			// stability timer restarts on every loss of lock
			// counts whole ms of unbroken lock against the committed setting
			if (!sy[SI_SLK]) begin
				nxt_s.stable = 1'b0;
				nxt_s.stab_ms = '0;
				nxt_s.stab_pre = '0;
			end else if (!s.stable) begin
				nxt_s.stab_pre = (s.stab_pre == 32'(MS_CYCLES - 1)) ? '0 :
					s.stab_pre + 32'h1;
				if (s.stab_pre == 32'(MS_CYCLES - 1)) nxt_s.stab_ms = s.stab_ms + 8'h1;
				nxt_s.stable = (s.stab_ms >= s.act.stab);
			end
			ev[EV_STABLE] = nxt_s.stable & ~s.stable;
			// watchdog in ms, zero period keeps it off
			// restart write clears both counters at once, no I/O update needed
			if ({s.act.wd_hi, s.act.wd_lo} == 16'h0 || wd_hit) begin
				nxt_s.wd_ms = '0;
				nxt_s.wd_pre = '0;
			end else begin
				nxt_s.wd_pre = (s.wd_pre == 32'(MS_CYCLES - 1)) ? '0 : s.wd_pre + 32'h1;
				if (s.wd_pre == 32'(MS_CYCLES - 1)) begin
					nxt_s.wd_ms = s.wd_ms + 16'h1;
					if (s.wd_ms + 16'h1 >= {s.act.wd_hi, s.act.wd_lo}) begin
						ev[EV_WD] = 1'b1;
						nxt_s.wd_ms = '0;
					end
				end
			end
			ev[EV_ALOCK] = sy[SI_ALK] & ~s.alk_q;
			ev[EV_AUNLOCK] = ~sy[SI_ALK] & s.alk_q;
			ev[EV_PLOCK] = sy[SI_PLK] & ~s.plk_q;
			ev[EV_FLOCK] = sy[SI_FLK] & ~s.flk_q;
			// a new event beats a clear in the same cycle
			// clears act at once; the mask is the committed copy
			nxt_s.irq_mon = (s.irq_mon & ~clr) | (ev & s.act.irq_mask);
		end
		nxt_s.alk_q = sy[SI_ALK];
		nxt_s.plk_q = sy[SI_PLK];
		nxt_s.flk_q = sy[SI_FLK];
		nxt_s.pin_q = sy[SI_MF+pin_idx];
		// IRQ pin drive per mode, default open-drain pulling low
		irq_act = |s.irq_mon;
		unique case (s.act.irq_mode[1:0])
			IRQ_OD_N: begin
				nxt_s.irq_out = 1'b0;
				nxt_s.irq_oe = irq_act;
			end
			IRQ_OD_P: begin
				nxt_s.irq_out = 1'b1;
				nxt_s.irq_oe = irq_act;
			end
			IRQ_PP_HI: begin
				nxt_s.irq_out = irq_act;
				nxt_s.irq_oe = 1'b1;
			end
			IRQ_PP_LO: begin
				nxt_s.irq_out = ~irq_act;
				nxt_s.irq_oe = 1'b1;
			end
		endcase
		// pad floats in reset until the mode is known again
		if (rst_now) nxt_s.irq_oe = 1'b0;
	end

	// state register
	// test reset loads the power-up state, so the internal pulse
	// still runs once it is released
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s <= ST_RST;
		end else begin
			s <= nxt_s;
		end
	end

	// outputs straight from state flops
	assign mf_out = s.act.mf_val;
	// the active copy is forced to defaults whenever dev_rst is set,
	// so the pin enables are already low in reset with no gate after the flop
	assign mf_oe = s.act.mf_dir;
	assign spi_sdo = s.sdo;
	assign spi_sdo_oe = s.sdo_oe;
	assign device_reset = s.dev_rst;
	assign hard_pin_mode = s.hard_pin;
	assign serial_is_spi = s.spi_mode;
	assign i2c_addr_sel = s.i2c_addr;
	assign eeprom_load = s.eep_load;
	assign eeprom_profile = s.eep_prof;
	assign system_clock_multiplier_stable = s.stable;
	assign user_free_run = s.act.loop[B_FREERUN];
	assign digital_loop_acquire = s.acquire;
	assign output_multiplier_loop_cal_start = s.cal_start;
	assign output_multiplier_loop_cfg_a = s.act.omc_a;
	assign output_multiplier_loop_cfg_b = s.act.omc_b;
	assign dist_out_enable = s.act.out_en;
	assign dist_sync = s.dist_sync;
	assign irq_out = s.irq_out;
	assign irq_oe = s.irq_oe;
endmodule : sc_startup_config_sequencer

// ### test/sc_config_monitor.sv
// sc_config_monitor: port-level timing checks on the start-up sequencer
// assumes a bind into the sequencer, with its timing parameters handed on
`timescale 1ns/1ps
module sc_config_monitor #(
	parameter int POR_CYCLES = 50,
	parameter int MS_CYCLES = 10
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic supplies_ok,
	input wire logic reset_pin_n,
	input wire logic system_clock_multiplier_pll_locked,
	input wire logic device_reset,
	input wire logic [7:0] mf_oe,
	input wire logic hard_pin_mode,
	input wire logic serial_is_spi,
	input wire logic eeprom_load,
	input wire logic [2:0] eeprom_profile,
	input wire logic [2:0] i2c_addr_sel,
	input wire logic system_clock_multiplier_stable,
	input wire logic user_free_run,
	input wire logic digital_loop_acquire,
	input wire logic output_multiplier_loop_cal_start,
	input wire logic dist_sync,
	input wire logic irq_out,
	input wire logic irq_oe
);
	import sc_pkg::*;
	int sup_cnt;
	int lock_cnt;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// saturating run lengths of supply-good and clock lock
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sup_cnt <= 0;
			lock_cnt <= 0;
		end else begin
			sup_cnt <= !supplies_ok ? 0 : (sup_cnt < 1000000 ? sup_cnt + 1 : sup_cnt);
			lock_cnt <= !system_clock_multiplier_pll_locked ? 0 : (lock_cnt < 1000000 ? lock_cnt + 1 : lock_cnt);
		end
	end
	chk_por_len: assert property ($fell(device_reset) |-> sup_cnt >= POR_CYCLES)
		else $error("internal reset ended early");
	chk_pin_tri: assert property (!reset_pin_n [*4] |-> mf_oe == 8'h00)
		else $error("pins still driven during pin reset");
	chk_mf_reset: assert property (device_reset |-> mf_oe == 8'h00)
		else $error("pins driven during internal reset");
	chk_strap_hold: assert property (!device_reset [*3] |-> $stable(serial_is_spi) &&
		$stable(i2c_addr_sel) && $stable(eeprom_load) && $stable(eeprom_profile) &&
		$stable(hard_pin_mode))
		else $error("captured straps changed outside reset");
	chk_hard_pin: assert property (hard_pin_mode |-> !serial_is_spi && !eeprom_load)
		else $error("hard pin mode did not override straps");
	chk_stable_time: assert property ($rose(system_clock_multiplier_stable) |->
		lock_cnt >= STAB_DEF_MS * MS_CYCLES)
		else $error("clock declared stable too soon");
	chk_cal_pulse: assert property (output_multiplier_loop_cal_start |=> !output_multiplier_loop_cal_start)
		else $error("calibration start longer than one cycle");
	chk_acq_fall: assert property (digital_loop_acquire |-> !user_free_run &&
		($past(user_free_run) || $past(user_free_run, 2)))
		else $error("acquisition without leaving free run");
	chk_sync_pulse: assert property (dist_sync |=> !dist_sync)
		else $error("sync pulse longer than one cycle");
	chk_irq_drain: assert property (irq_oe |-> !irq_out)
		else $error("interrupt pad not pulling low");
endmodule : sc_config_monitor

// ### test/sc_host_model.sv
// sc_host_model: serial port host, one byte per chip-select frame
// assumes the sequencer strapped for the serial port, sclk high 10 cycles and low 11
`timescale 1ns/1ps
module sc_host_model (
	input wire logic sys_clk,
	input wire logic spi_sdo,
	input wire logic spi_sdo_oe,
	output logic spi_sclk,
	output logic spi_csb,
	output logic spi_sdi
);
	import sc_pkg::*;
	// idle bus at time zero
	initial begin
		spi_sclk = 1'b0;
		spi_csb = 1'b1;
		spi_sdi = 1'b1;
	end
	// instruction then data, msb first; read bits taken at rising sclk
	task automatic xfer(input logic rd, input sc_addr_type a, input sc_byte_type wd,
		output sc_byte_type rdat);
		logic [23:0] f;
		f = {rd, a, wd};
		rdat = 8'h00;
		@(posedge sys_clk) spi_csb <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			@(posedge sys_clk) spi_sdi <= f[i];
			repeat (10) @(posedge sys_clk);
			spi_sclk <= 1'b1;
			if (i < 8) rdat[i] = spi_sdo_oe ? spi_sdo : ~spi_sdo; // undriven line reads wrong
			repeat (10) @(posedge sys_clk);
			spi_sclk <= 1'b0;
		end
		repeat (4) @(posedge sys_clk);
		spi_csb <= 1'b1;
		spi_sdi <= ~f[0]; // released line shows no stale bit
		repeat (6) @(posedge sys_clk);
	endtask : xfer
endmodule : sc_host_model

// ### test/sc_startup_config_sequencer_tb.sv
// sc_startup_config_sequencer_tb: register-level sequences through the host model
// assumes shortened reset and millisecond counts given as parameters below
`timescale 1ns/1ps
module sc_startup_config_sequencer_tb;
	import sc_pkg::*;
	logic sys_clk, resetn, supplies_ok, reset_pin_n, hard_pin_select;
	logic [3:0] strap_float;
	sc_byte_type mf_in, output_multiplier_loop_cfg_a, output_multiplier_loop_cfg_b, dist_out_enable;
	logic [7:0] mf_out, mf_oe;
	logic spi_sclk, spi_csb, spi_sdi, spi_sdo, spi_sdo_oe;
	logic system_clock_multiplier_pll_locked, output_multiplier_loop_locked, digital_loop_phase_lock, digital_loop_freq_lock;
	logic device_reset, hard_pin_mode, serial_is_spi, eeprom_load, system_clock_multiplier_stable;
	logic [2:0] i2c_addr_sel, eeprom_profile;
	logic user_free_run, digital_loop_acquire, output_multiplier_loop_cal_start, dist_sync, irq_out, irq_oe;
	int bad_count = 0;
	int checked = 0;
	int n_cal = 0;
	int n_acq = 0;
	int n_sync = 0;
	sc_startup_config_sequencer #(.POR_CYCLES(50), .MS_CYCLES(10),
		.SILICON_REV(8'h3C)) sc_startup_config_sequencer_i ( // arbitrary revision
		.sys_clk(sys_clk), .resetn(resetn), .supplies_ok(supplies_ok),
		.reset_pin_n(reset_pin_n), .hard_pin_select(hard_pin_select),
		.strap_float(strap_float), .mf_in(mf_in), .mf_out(mf_out), .mf_oe(mf_oe),
		.spi_sclk(spi_sclk), .spi_csb(spi_csb), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
		.spi_sdo_oe(spi_sdo_oe), .system_clock_multiplier_pll_locked(system_clock_multiplier_pll_locked),
		.output_multiplier_loop_locked(output_multiplier_loop_locked), .digital_loop_phase_lock(digital_loop_phase_lock),
		.digital_loop_freq_lock(digital_loop_freq_lock), .device_reset(device_reset),
		.hard_pin_mode(hard_pin_mode), .serial_is_spi(serial_is_spi),
		.i2c_addr_sel(i2c_addr_sel), .eeprom_load(eeprom_load),
		.eeprom_profile(eeprom_profile), .system_clock_multiplier_stable(system_clock_multiplier_stable),
		.user_free_run(user_free_run), .digital_loop_acquire(digital_loop_acquire),
		.output_multiplier_loop_cal_start(output_multiplier_loop_cal_start), .output_multiplier_loop_cfg_a(output_multiplier_loop_cfg_a), .output_multiplier_loop_cfg_b(output_multiplier_loop_cfg_b),
		.dist_out_enable(dist_out_enable), .dist_sync(dist_sync), .irq_out(irq_out),
		.irq_oe(irq_oe));
	sc_host_model sc_host_model_i (.sys_clk(sys_clk), .spi_sdo(spi_sdo),
		.spi_sdo_oe(spi_sdo_oe), .spi_sclk(spi_sclk), .spi_csb(spi_csb), .spi_sdi(spi_sdi));
	// clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// count one-cycle pulses
	always @(posedge sys_clk) begin
		if (output_multiplier_loop_cal_start === 1'b1) n_cal++;
		if (digital_loop_acquire === 1'b1) n_acq++;
		if (dist_sync === 1'b1) n_sync++;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input sc_addr_type a, input sc_byte_type d);
		sc_byte_type x;
		sc_host_model_i.xfer(1'b0, a, d, x);
	endtask : wr
	task automatic rd(input sc_addr_type a, input sc_byte_type exp);
		sc_byte_type x;
		sc_host_model_i.xfer(1'b1, a, 8'h00, x);
		chk(x, exp);
	endtask : rd
	task automatic upd;
		wr(A_IO_UPD, 8'h01);
	endtask : upd
	task automatic summarize;
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize
	// hang guard
	initial begin
		repeat (60000) @(posedge sys_clk);
		bad_count++;
		summarize();
	end
	// main sequence
	initial begin
		resetn = 1'b0;
		supplies_ok = 1'b1;
		reset_pin_n = 1'b1;
		hard_pin_select = 1'b0;
		strap_float = 4'h0;
		mf_in = 8'h08;
		{system_clock_multiplier_pll_locked, output_multiplier_loop_locked, digital_loop_phase_lock, digital_loop_freq_lock} = 4'h0;
		repeat (4) @(posedge sys_clk);
		chk(device_reset, 8'h01);
		chk(output_multiplier_loop_cfg_a, 8'h81);
		chk(output_multiplier_loop_cfg_b, 8'h07);
		chk(dist_out_enable, 8'h00);
		chk(irq_oe, 8'h00);
		resetn <= 1'b1;
		repeat (30) @(posedge sys_clk);
		chk(device_reset, 8'h01);
		repeat (40) @(posedge sys_clk);
		chk(device_reset, 8'h00);
		chk(serial_is_spi, 8'h01);
		chk({eeprom_load, 4'h0, eeprom_profile}, 8'h85);
		chk(hard_pin_mode, 8'h00);
		mf_in <= 8'hF7;
		system_clock_multiplier_pll_locked <= 1'b1;
		repeat (400) @(posedge sys_clk);
		chk(system_clock_multiplier_stable, 8'h00);
		rd(A_REV, 8'h3C);
		rd(15'h0123, 8'h00);
		rd(A_IO_UPD, 8'h00);
		chk(system_clock_multiplier_stable, 8'h01);
		chk({serial_is_spi, 4'h0, eeprom_profile}, 8'h85);
		wr(A_STAB, 8'h32);
		rd(A_STAB, 8'h32);
		// pending writes wait for the update
		wr(A_OMC_A, 8'h55);
		wr(A_OUT_EN, 8'h3F);
		chk(output_multiplier_loop_cfg_a, 8'h81);
		rd(A_OMC_A, 8'h55);
		upd();
		chk(output_multiplier_loop_cfg_a, 8'h55);
		chk(dist_out_enable, 8'h3F);
		// recommended values, then calibration edges
		wr(A_OMC_A, 8'h81);
		wr(A_OMC_B, 8'h07);
		wr(A_VCO, 8'h21);
		upd();
		chk(n_cal[7:0], 8'h01);
		upd();
		chk(n_cal[7:0], 8'h01);
		wr(A_VCO, 8'h20);
		upd();
		wr(A_VCO, 8'h21);
		upd();
		chk(n_cal[7:0], 8'h02);
		// masked event, status, pad and clears
		wr(A_IRQ_MASK, 8'h62);
		upd();
		output_multiplier_loop_locked <= 1'b1;
		rd(A_PLL_ST, 8'h07);
		rd(A_IRQ_MON, 8'h02);
		chk({irq_oe, irq_out}, 8'h02);
		wr(A_IRQ_CLR, 8'h02);
		rd(A_IRQ_MON, 8'h00);
		chk(irq_oe, 8'h00);
		// watchdog at 200 ms, restarted then expiring
		wr(A_WD_LO, 8'hC8);
		upd();
		wr(A_CLR, 8'h01);
		rd(A_IRQ_MON, 8'h00);
		repeat (2000) @(posedge sys_clk);
		rd(A_IRQ_MON, 8'h40);
		wr(A_WD_LO, 8'h00);
		upd();
		wr(A_CLR, 8'h02);
		rd(A_IRQ_MON, 8'h00);
		// free run entry and exit
		wr(A_LOOP, 8'h20);
		upd();
		chk(user_free_run, 8'h01);
		wr(A_LOOP, 8'h00);
		upd();
		chk({user_free_run, 7'h0} | n_acq[7:0], 8'h01);
		// automatic then soft sync
		wr(A_SYNC_MODE, 8'h01);
		upd();
		digital_loop_phase_lock <= 1'b1;
		repeat (10) @(posedge sys_clk);
		chk(n_sync[7:0], 8'h01);
		rd(A_IRQ_MON, 8'h20);
		wr(A_SYNC_MODE, 8'h00);
		wr(A_SSYNC, 8'h02);
		upd();
		chk(n_sync[7:0], 8'h01);
		wr(A_SSYNC, 8'h00);
		upd();
		chk(n_sync[7:0], 8'h02);
		// sync from a rising edge on multifunction pin 4
		wr(A_SYNC_PIN, 8'h0C);
		upd();
		mf_in <= 8'hE7;
		repeat (6) @(posedge sys_clk);
		chk(n_sync[7:0], 8'h02);
		mf_in <= 8'hF7;
		repeat (6) @(posedge sys_clk);
		chk(n_sync[7:0], 8'h03);
		// pin reset tri-states pins and recaptures straps
		wr(A_MF_VAL, 8'hA5);
		wr(A_MF_DIR, 8'hFF);
		upd();
		chk(mf_out, 8'hA5);
		chk(mf_oe, 8'hFF);
		mf_in <= 8'h00;
		strap_float <= 4'hD;
		reset_pin_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk(mf_oe, 8'h00);
		reset_pin_n <= 1'b1;
		repeat (10) @(posedge sys_clk);
		chk({serial_is_spi, eeprom_load, 3'h0, i2c_addr_sel}, 8'h00);
		hard_pin_select <= 1'b1;
		reset_pin_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		reset_pin_n <= 1'b1;
		repeat (10) @(posedge sys_clk);
		chk({hard_pin_mode, serial_is_spi}, 8'h02);
		summarize();
	end
endmodule : sc_startup_config_sequencer_tb
bind sc_startup_config_sequencer sc_config_monitor #(.POR_CYCLES(POR_CYCLES),
	.MS_CYCLES(MS_CYCLES)) sc_config_monitor_i (.sys_clk(sys_clk), .resetn(resetn),
	.supplies_ok(supplies_ok), .reset_pin_n(reset_pin_n),
	.system_clock_multiplier_pll_locked(system_clock_multiplier_pll_locked), .device_reset(device_reset), .mf_oe(mf_oe),
	.hard_pin_mode(hard_pin_mode), .serial_is_spi(serial_is_spi),
	.eeprom_load(eeprom_load), .eeprom_profile(eeprom_profile),
	.i2c_addr_sel(i2c_addr_sel), .system_clock_multiplier_stable(system_clock_multiplier_stable),
	.user_free_run(user_free_run), .digital_loop_acquire(digital_loop_acquire),
	.output_multiplier_loop_cal_start(output_multiplier_loop_cal_start), .dist_sync(dist_sync), .irq_out(irq_out),
	.irq_oe(irq_oe));
